/* hdl/supervisory_pkg.sv */
// Contract
// [RQ1] Second alarm register bit order fixed
// [RQ2] Current share mismatch over 10A flags fault
// [RQ3] First alarm register bit order fixed
// [RQ4] Output below 39V is over-current, shutdown
// [RQ5] Alarm bits: zero normal, one alarm
// [RQ6] D2h blinks four lamps 7s on 2s off
// [RQ7] D3h stops identification, lamps off; code returns lamp_o to the normal lamps
// [RQ8] D4h flashes remove indicator half second
// [RQ9] D5h holds remove indicator off
// [RQ10] EEPROM top protected; D6h unprotects after 10ms
// [RQ11] D7h restores EEPROM top protection
// [RQ12] Limit above 36V keeps output lamp blinking
// [RQ13] Auto-restart hiccups; lamp follows state, latched off
// [RQ14] D8h sets sticky inhibit, latch off faults
// [RQ15] Leave latch after 2s off or restart
// [RQ16] Successful restart clears alarms, sets flag
// [RQ17] Restart flag is status two bit 2
// [RQ18] D9h clears inhibit, automatic restart again
// [RQ19] Over-voltage: 1s delay, three tries per minute
// [RQ20] Three failures latch; window expiry resets count
// [RQ21] DAh starts output OR-ing self-test
// [RQ22] Host checks redundancy, tests one unit
// [RQ23] Host keeps supplies off 20-30s
// [RQ24] Any alarm or status change raises alert
// [RQ25] Commands arrive as send-byte, no data
package supervisory_pkg;
  // Send-byte command codes
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h03;
  localparam logic [7:0] CMD_IDENTIFY_START = 8'hd2;
  localparam logic [7:0] CMD_IDENTIFY_STOP = 8'hd3;
  localparam logic [7:0] CMD_REMOVE_FLASH = 8'hd4;
  localparam logic [7:0] CMD_REMOVE_OFF = 8'hd5;
  localparam logic [7:0] CMD_WP_LIFT = 8'hd6;
  localparam logic [7:0] CMD_WP_SET = 8'hd7;
  localparam logic [7:0] CMD_INHIBIT = 8'hd8;
  localparam logic [7:0] CMD_AUTO_RESTART = 8'hd9;
  localparam logic [7:0] CMD_ISO_TEST = 8'hda;
  // Alarm two bit positions
  localparam int A2_FAN = 7;
  localparam int A2_NO_PRIMARY = 6;
  localparam int A2_PRI_OT = 5;
  localparam int A2_DCDC_OT = 4;
  localparam int A2_BELOW_BUS = 3;
  localparam int A2_SENSOR = 2;
  localparam int A2_AUX = 1;
  localparam int A2_DELIVERY = 0;
  // Alarm one bit positions
  localparam int A1_POWER_LIMIT = 7;
  localparam int A1_PRIMARY = 6;
  localparam int A1_OT_SHUTDOWN = 5;
  localparam int A1_OT_WARNING = 4;
  localparam int A1_OVER_CURRENT = 3;
  localparam int A1_OV_SHUTDOWN = 2;
  localparam int A1_VOUT_OOR = 1;
  localparam int A1_VIN_OOR = 0;
  // Status two restart flag position
  localparam int S2_RESTART_OK = 2;
  // Reset values
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic WP_RESET = 1'b1;
  // Analog thresholds, 0.1 V and 0.1 A units
  localparam logic [9:0] OC_VOLT_LIMIT = 10'd390;
  localparam logic [9:0] BLINK_VOLT_LIMIT = 10'd360;
  localparam logic [9:0] SHARE_CURRENT_LIMIT = 10'd100;
  // Time base: one tick per millisecond
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDENT_ON_MS = 7000;
  localparam int IDENT_OFF_MS = 2000;
  localparam int REMOVE_HALF_MS = 500;
  localparam int BLINK_HALF_MS = 500;
  localparam int WP_DELAY_MS = 10;
  localparam int OFF_HOLD_MS = 2000;
  localparam int RETRY_DELAY_MS = 1000;
  localparam int OV_WINDOW_MS = 60000;
  localparam logic [1:0] OV_MAX_TRIES = 2'd3;
  // Supervisory states
  typedef enum logic [1:0] {ST_RUN, ST_RETRY, ST_LATCHED} power_state_type;
endpackage

/* hdl/supervisory_command_alarm_logic.sv */
`timescale 1ns/1ps
module supervisory_command_alarm_logic
  import supervisory_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  // Link side, decoded send-byte commands
  input wire logic link_clk_i,
  input wire logic cmd_strobe_i,
  input wire logic [7:0] cmd_code_i,
  output logic cmd_busy_o,
  // Monitor pins, asynchronous levels
  input wire logic [7:0] alarm_two_src_i,
  input wire logic [7:0] alarm_one_src_i,
  input wire logic enable_off_i,
  input wire logic host_off_i,
  // Measurements from on-chip converters and alert acknowledge, same clock
  input wire logic [9:0] vout_i,
  input wire logic [9:0] own_current_i,
  input wire logic [9:0] share_current_i,
  input wire logic alert_ack_i,
  // Register contents and indicators
  output logic [7:0] alarm_two_o,
  output logic [7:0] alarm_one_o,
  output logic [7:0] status_two_o,
  output logic output_on_o,
  output logic [3:0] lamp_o,
  output logic remove_lamp_o,
  output logic eeprom_wp_o,
  output logic inhibit_o,
  output logic iso_test_start_o,
  output logic smbalert_out_o,
  output logic smbalert_oe_o
);

  // Link-domain command capture
  logic [7:0] link_code_r; // Held command byte
  logic link_tog_r; // Toggles per command
  logic [1:0] link_ack_sync_r; // Ack toggle synchroniser
  logic link_take; // Command accepted
  logic core_ack_r; // Echo back to link, core domain

  assign cmd_busy_o = link_tog_r != link_ack_sync_r[1];
  assign link_take = cmd_strobe_i && !cmd_busy_o;

  // Hold byte until the core echoes the toggle
  always_ff @(posedge link_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      link_code_r <= 8'h00;
      link_tog_r <= 1'b0;
      link_ack_sync_r <= 2'b00;
    end
    else
    begin
      link_ack_sync_r <= {link_ack_sync_r[0], core_ack_r};
      if (link_take) // see [RQ25]
      begin
        link_code_r <= cmd_code_i;
        link_tog_r <= ~link_tog_r;
      end
    end
  end

  // Core-domain command reception
  logic [2:0] core_tog_sync_r; // Two stages plus edge memory
  logic cmd_new; // One-cycle command event
  logic [7:0] cmd_r; // Command byte in core domain
  logic cmd_valid_r; // Registered event

  assign cmd_new = core_tog_sync_r[2] != core_tog_sync_r[1];

  // Byte is stable while the toggle is in flight
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      core_tog_sync_r <= 3'b000;
      core_ack_r <= 1'b0;
      cmd_r <= 8'h00;
      cmd_valid_r <= 1'b0;
    end
    else
    begin
      core_tog_sync_r <= {core_tog_sync_r[1:0], link_tog_r};
      cmd_valid_r <= cmd_new;
      if (cmd_new)
      begin
        cmd_r <= link_code_r;
        core_ack_r <= core_tog_sync_r[1];
      end
    end
  end

  // Command decode
  wire cmd_ident_start = cmd_valid_r && cmd_r == CMD_IDENTIFY_START;
  wire cmd_ident_stop = cmd_valid_r && cmd_r == CMD_IDENTIFY_STOP;
  wire cmd_remove_flash = cmd_valid_r && cmd_r == CMD_REMOVE_FLASH;
  wire cmd_remove_off = cmd_valid_r && cmd_r == CMD_REMOVE_OFF;
  wire cmd_wp_lift = cmd_valid_r && cmd_r == CMD_WP_LIFT;
  wire cmd_wp_set = cmd_valid_r && cmd_r == CMD_WP_SET;
  wire cmd_inhibit = cmd_valid_r && cmd_r == CMD_INHIBIT;
  wire cmd_auto = cmd_valid_r && cmd_r == CMD_AUTO_RESTART;
  wire cmd_iso = cmd_valid_r && cmd_r == CMD_ISO_TEST;
  wire cmd_clear = cmd_valid_r && cmd_r == CMD_CLEAR_FLAGS;

  // Pin synchronisers
  logic [17:0] pin_meta_r; // First stage only
  logic [17:0] pin_r; // Second stage, safe to use

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta_r <= 18'h00000;
      pin_r <= 18'h00000;
    end
    else
    begin
      pin_meta_r <= {enable_off_i, host_off_i, alarm_two_src_i, alarm_one_src_i};
      pin_r <= pin_meta_r;
    end
  end

  wire [7:0] a1_pin = pin_r[7:0];
  wire [7:0] a2_pin = pin_r[15:8];
  wire off_request = pin_r[16] || pin_r[17];

  // Millisecond tick
  logic [15:0] pre_r; // Prescaler
  wire tick = pre_r == 16'(TICK_CYCLES_P - 1);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      pre_r <= 16'h0000;
    else
      pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
  end

  // Analog comparisons
  wire [9:0] share_diff = own_current_i > share_current_i ? own_current_i - share_current_i
                                                          : share_current_i - own_current_i;
  wire delivery_fault = share_diff > SHARE_CURRENT_LIMIT; // see [RQ2]
  power_state_type state_r; // Output state
  wire power_state_on = state_r == ST_RUN;
  wire oc_event = power_state_on && vout_i < OC_VOLT_LIMIT; // see [RQ4]
  wire ov_event = power_state_on && a1_pin[A1_OV_SHUTDOWN];
  wire ot_event = power_state_on && a1_pin[A1_OT_SHUTDOWN];
  wire shutdown_event = oc_event || ov_event || ot_event;

  // Live alarm conditions; one means alarm
  wire [7:0] a2_live = {a2_pin[7:1], delivery_fault}; // see [RQ1]
  wire [7:0] a1_live = {a1_pin[7:4], a1_pin[A1_OVER_CURRENT] | oc_event, a1_pin[2:0]}; // see [RQ3]

  // Supervisory state machine
  power_state_type state_nxt;
  logic [15:0] wait_r; // Retry delay / off hold count
  logic [15:0] win_r; // Over-voltage window count
  logic win_run_r; // Window open
  logic [1:0] ov_tries_r; // Over-voltage attempts in window
  logic inhibit_r; // Sticky latch-off choice
  logic restarted; // Entering run from shutdown

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (shutdown_event && inhibit_r)
          state_nxt = ST_LATCHED; // see [RQ14]
        else if (ov_event && ov_tries_r == OV_MAX_TRIES)
          state_nxt = ST_LATCHED; // see [RQ20]
        else if (shutdown_event)
          state_nxt = ST_RETRY; // see [RQ13]
      ST_RETRY:
        if (tick && wait_r == 16'(RETRY_DELAY_MS - 1))
          state_nxt = ST_RUN; // see [RQ19]
      ST_LATCHED:
        if (cmd_auto || (!off_request && wait_r >= 16'(OFF_HOLD_MS)))
          state_nxt = ST_RUN; // see [RQ15]
      default:
        state_nxt = ST_RUN;
    endcase
  end

  assign restarted = state_r != ST_RUN && state_nxt == ST_RUN;

  // State and waiting counter
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= ST_RUN;
      wait_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        wait_r <= 16'h0000;
      else if (state_r == ST_LATCHED && off_request && tick && wait_r < 16'(OFF_HOLD_MS))
        wait_r <= wait_r + 16'h0001; // see [RQ15]
      else if (state_r == ST_LATCHED && !off_request && wait_r < 16'(OFF_HOLD_MS))
        wait_r <= 16'h0000;
      else if (state_r == ST_RETRY && tick)
        wait_r <= wait_r + 16'h0001;
    end
  end

  // Over-voltage attempt counting per minute window
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      win_r <= 16'h0000;
      win_run_r <= 1'b0;
      ov_tries_r <= 2'd0;
    end
    else if (state_r == ST_LATCHED)
    begin
      win_run_r <= 1'b0;
      ov_tries_r <= 2'd0;
    end
    else if (ov_event && ov_tries_r != OV_MAX_TRIES)
    begin
      ov_tries_r <= ov_tries_r + 2'd1; // see [RQ19]
      if (!win_run_r)
      begin
        win_run_r <= 1'b1;
        win_r <= 16'h0000;
      end
    end
    else if (win_run_r && tick)
    begin
      if (win_r == 16'(OV_WINDOW_MS - 1))
      begin
        win_run_r <= 1'b0; // see [RQ20]
        ov_tries_r <= 2'd0;
      end
      else
        win_r <= win_r + 16'h0001;
    end
  end

  // Inhibit flag, kept while bias is present
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      inhibit_r <= 1'b0;
    else if (cmd_inhibit)
      inhibit_r <= 1'b1; // see [RQ14]
    else if (cmd_auto)
      inhibit_r <= 1'b0; // see [RQ18]
  end

  // Alarm registers: sticky, cleared by a successful restart
  logic [7:0] alarm_two_r;
  logic [7:0] alarm_one_r;
  logic restart_ok_r; // Status two restart flag

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      alarm_two_r <= ALARM_RESET;
      alarm_one_r <= ALARM_RESET;
      restart_ok_r <= 1'b0;
    end
    else
    begin
      // Live events win over the restart clear
      alarm_two_r <= restarted ? a2_live : (alarm_two_r | a2_live); // see [RQ5]
      alarm_one_r <= restarted ? a1_live : (alarm_one_r | a1_live); // see [RQ16]
      if (restarted)
        restart_ok_r <= 1'b1; // see [RQ16]
      else if (cmd_clear)
        restart_ok_r <= 1'b0;
    end
  end

  assign alarm_two_o = alarm_two_r;
  assign alarm_one_o = alarm_one_r;
  assign status_two_o = 8'(restart_ok_r) << S2_RESTART_OK; // see [RQ17]
  assign inhibit_o = inhibit_r;
  assign output_on_o = power_state_on;

  // Alert on any register pattern change
  logic [16:0] prev_r; // Last seen pattern
  logic alert_r; // Pin pulled while set
  wire [16:0] pattern = {restart_ok_r, alarm_two_r, alarm_one_r};
  wire pattern_change = pattern != prev_r;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prev_r <= 17'h00000;
      alert_r <= 1'b0;
    end
    else
    begin
      prev_r <= pattern;
      if (pattern_change)
        alert_r <= 1'b1; // see [RQ24]
      else if (alert_ack_i)
        alert_r <= 1'b0;
    end
  end

  assign smbalert_out_o = 1'b0;
  assign smbalert_oe_o = alert_r;

  // Indicator timers
  logic ident_r; // Identification running
  logic ident_lit_r; // Lit phase
  logic [15:0] ident_cnt_r;
  logic remove_r; // Remove flash running
  logic remove_lit_r;
  logic [15:0] remove_cnt_r;
  logic blink_r; // Free half-second blink
  logic [15:0] blink_cnt_r;

  // Identification cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ident_r <= 1'b0;
      ident_lit_r <= 1'b0;
      ident_cnt_r <= 16'h0000;
    end
    else if (cmd_ident_start)
    begin
      ident_r <= 1'b1; // see [RQ6]
      ident_lit_r <= 1'b1;
      ident_cnt_r <= 16'h0000;
    end
    else if (cmd_ident_stop)
    begin
      ident_r <= 1'b0; // see [RQ7]
      ident_lit_r <= 1'b0;
    end
    else if (ident_r && tick)
    begin
      if (ident_cnt_r == 16'((ident_lit_r ? IDENT_ON_MS : IDENT_OFF_MS) - 1))
      begin
        ident_cnt_r <= 16'h0000;
        ident_lit_r <= ~ident_lit_r; // see [RQ6]
      end
      else
        ident_cnt_r <= ident_cnt_r + 16'h0001;
    end
  end

  // Remove indicator flash
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      remove_r <= 1'b0;
      remove_lit_r <= 1'b0;
      remove_cnt_r <= 16'h0000;
    end
    else if (cmd_remove_flash)
    begin
      remove_r <= 1'b1; // see [RQ8]
      remove_lit_r <= 1'b1;
      remove_cnt_r <= 16'h0000;
    end
    else if (cmd_remove_off)
    begin
      remove_r <= 1'b0; // see [RQ9]
      remove_lit_r <= 1'b0;
    end
    else if (remove_r && tick)
    begin
      if (remove_cnt_r == 16'(REMOVE_HALF_MS - 1))
      begin
        remove_cnt_r <= 16'h0000;
        remove_lit_r <= ~remove_lit_r; // see [RQ8]
      end
      else
        remove_cnt_r <= remove_cnt_r + 16'h0001;
    end
  end

  // Output lamp blink base
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      blink_r <= 1'b0;
      blink_cnt_r <= 16'h0000;
    end
    else if (tick)
    begin
      if (blink_cnt_r == 16'(BLINK_HALF_MS - 1))
      begin
        blink_cnt_r <= 16'h0000;
        blink_r <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 16'h0001;
    end
  end

  // Lamp selection
  wire in_limit = a1_pin[A1_POWER_LIMIT] || a1_pin[A1_OVER_CURRENT];
  wire out_blink = in_limit && vout_i > BLINK_VOLT_LIMIT; // see [RQ12]
  wire out_lamp = power_state_on && (out_blink ? blink_r : 1'b1); // see [RQ13]
  wire [3:0] normal_lamps = {|alarm_two_r, remove_r, out_lamp, !a1_pin[A1_VIN_OOR]};
  wire [3:0] lamps_nxt = ident_r ? {4{ident_lit_r}} : normal_lamps;

  // Write-protect with deferred lift
  logic wp_r; // Protection active
  logic wp_pend_r; // Lift requested
  logic [3:0] wp_cnt_r;
  logic iso_r;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wp_r <= WP_RESET; // see [RQ10]
      wp_pend_r <= 1'b0;
      wp_cnt_r <= 4'h0;
      lamp_o <= 4'h0;
      remove_lamp_o <= 1'b0;
      iso_r <= 1'b0;
    end
    else
    begin
      lamp_o <= lamps_nxt;
      remove_lamp_o <= remove_lit_r;
      iso_r <= cmd_iso; // see [RQ21]
      if (cmd_wp_set)
      begin
        wp_r <= 1'b1; // see [RQ11]
        wp_pend_r <= 1'b0;
      end
      else if (cmd_wp_lift)
      begin
        wp_pend_r <= 1'b1;
        wp_cnt_r <= 4'h0;
      end
      else if (wp_pend_r && tick)
      begin
        if (wp_cnt_r == 4'(WP_DELAY_MS - 1))
        begin
          wp_r <= 1'b0; // see [RQ10]
          wp_pend_r <= 1'b0;
        end
        else
          wp_cnt_r <= wp_cnt_r + 4'h1;
      end
    end
  end

  assign eeprom_wp_o = wp_r;
  assign iso_test_start_o = iso_r;

  // Checks
  ident_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_ident_stop |=> ##1 lamp_o == $past(normal_lamps)) else $error("identify stop ignored"); // see [RQ7]
  ident_lamps_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ident_r |=> lamp_o == {4{$past(ident_lit_r)}}) else $error("lamps not together"); // see [RQ6]
  remove_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_remove_off |=> ##1 !remove_lamp_o) else $error("remove lamp not off"); // see [RQ9]
  wp_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_wp_set |=> eeprom_wp_o) else $error("protection not restored"); // see [RQ11]
  wp_early_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(eeprom_wp_o) |-> wp_cnt_r == 4'(WP_DELAY_MS - 1)) else $error("protection lifted early"); // see [RQ10]
  inhibit_latch_a: assert property (@(posedge clk_i) disable iff (reset_i)
    inhibit_r && shutdown_event |=> state_r == ST_LATCHED) else $error("inhibit did not latch"); // see [RQ14]
  auto_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_auto |=> !inhibit_r) else $error("inhibit not cleared"); // see [RQ18]
  restart_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
    restarted |=> status_two_o[S2_RESTART_OK] && alarm_one_r == $past(a1_live)) else $error("restart not flagged"); // see [RQ16]
  latched_dark_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_r == ST_LATCHED && !ident_r |=> !lamp_o[1]) else $error("output lamp lit while latched"); // see [RQ13]
  delivery_bit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    delivery_fault |=> alarm_two_r[A2_DELIVERY]) else $error("delivery fault missed"); // see [RQ2]
  alert_raise_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pattern_change |=> smbalert_oe_o) else $error("alert not raised"); // see [RQ24]
  ov_limit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ov_event && ov_tries_r == OV_MAX_TRIES |=> state_r == ST_LATCHED) else $error("fourth try allowed"); // see [RQ20]
endmodule

/* verification/host_cmd_model.sv */
`timescale 1ns/1ps
// Host end of the command link, one send-byte at a time
module host_cmd_model
(
  input wire logic link_clk_i,
  input wire logic cmd_busy_i,
  output logic cmd_strobe_o,
  output logic [7:0] cmd_code_o
);
  // Link idle at time zero
  initial
  begin
    cmd_strobe_o = 1'b0;
    cmd_code_o = 8'h00;
  end

  // Command byte only, no data byte follows
  task automatic send(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge link_clk_i);
    // Wait up to 64 link cycles for a command still crossing
    while (cmd_busy_i !== 1'b0 && n < 64)
    begin
      @(negedge link_clk_i);
      n++;
    end
    cmd_strobe_o = 1'b1;
    cmd_code_o = c;
    // Held across one rising edge, then dropped
    @(negedge link_clk_i);
    cmd_strobe_o = 1'b0;
    // Released code line shows no stale value
    cmd_code_o = ~c;
  endtask
endmodule

/* verification/supervisory_command_alarm_logic_tb_top.sv */
`timescale 1ns/1ps
// Bench top: monitors, commands and a reference model
module supervisory_command_alarm_logic_tb_top;
  import supervisory_pkg::*;
  localparam int TK = 4; // Core cycles per tick
  logic clk_i = 1'b0; // Core clock
  logic link_clk_i = 1'b0; // Link clock
  logic reset_i = 1'b1; // Reset held at start
  logic cmd_strobe_i;
  logic [7:0] cmd_code_i;
  logic [7:0] alarm_two_src_i = 8'h00; // Monitor levels
  logic [7:0] alarm_one_src_i = 8'h00;
  logic enable_off_i = 1'b0; // Off requests
  logic host_off_i = 1'b0;
  logic [9:0] vout_i = 10'd540; // 54.0 V
  logic [9:0] own_current_i = 10'd0;
  logic [9:0] share_current_i = 10'd0;
  logic alert_ack_i = 1'b0;
  logic cmd_busy_o, output_on_o, remove_lamp_o, eeprom_wp_o, inhibit_o;
  logic iso_test_start_o, smbalert_out_o, smbalert_oe_o;
  logic [7:0] alarm_two_o, alarm_one_o, status_two_o;
  logic [3:0] lamp_o;
  logic [7:0] exp_a2; // Model of alarm two
  logic [31:0] seed = 32'h0157; // Random state
  int error_cnt = 0;
  int cmp_count = 0;

  // Clocks, unrelated in phase
  always #12.5 clk_i = ~clk_i;
  always #24 link_clk_i = ~link_clk_i;

  supervisory_command_alarm_logic #(.TICK_CYCLES_P(TK)) supervisory_command_alarm_logic_i (
    .clk_i, .reset_i, .link_clk_i, .cmd_strobe_i, .cmd_code_i, .cmd_busy_o,
    .alarm_two_src_i, .alarm_one_src_i, .enable_off_i, .host_off_i, .vout_i,
    .own_current_i, .share_current_i, .alert_ack_i, .alarm_two_o, .alarm_one_o,
    .status_two_o, .output_on_o, .lamp_o, .remove_lamp_o, .eeprom_wp_o,
    .inhibit_o, .iso_test_start_o, .smbalert_out_o, .smbalert_oe_o
  );
  host_cmd_model host_cmd_model_i (
    .link_clk_i, .cmd_busy_i(cmd_busy_o), .cmd_strobe_o(cmd_strobe_i), .cmd_code_o(cmd_code_i)
  );

  // Xorshift step
  function automatic logic [31:0] rnd(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Conditions waited on
  function automatic logic cond(input int k);
    case (k)
      0: return cmd_busy_o === 1'b0;
      1: return output_on_o === 1'b1;
      2: return output_on_o === 1'b0;
      3: return iso_test_start_o === 1'b1;
      default: return smbalert_oe_o === 1'b1;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait; a timeout counts and ends the run
  task automatic await(input int k, input int lim);
    int n;
    n = 0;
    while (!cond(k) && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (!cond(k))
    begin
      check(k, 32'hff);
      test_done();
    end
  endtask
  // Command through the host model, then let it act
  task automatic send(input logic [7:0] c);
    host_cmd_model_i.send(c);
    cyc(2);
    await(0, 100);
    cyc(4);
  endtask
  task automatic ack;
    alert_ack_i = 1'b1;
    cyc(1);
    alert_ack_i = 1'b0;
    cyc(3);
  endtask

  initial
  begin
    cyc(5);
    reset_i = 1'b0;
    cyc(4);
    check({alarm_two_o, alarm_one_o, status_two_o}, 24'h0);
    check({eeprom_wp_o, output_on_o, inhibit_o, remove_lamp_o, smbalert_out_o}, 5'h18);
    // Random alarm two sources, share gap at most 10 A
    exp_a2 = 8'h00;
    for (int i = 0; i < 12; i++)
    begin
      seed = rnd(seed);
      alarm_two_src_i = seed[7:0] & seed[15:8] & seed[23:16] & 8'hfe;
      own_current_i = 10'd100 + seed[24:16];
      share_current_i = own_current_i - ((i == 0) ? 10'd100 : 10'(seed[31:26] + seed[28:25]));
      exp_a2 = exp_a2 | alarm_two_src_i;
      cyc(6);
      alarm_two_src_i = 8'h00;
      cyc(6);
      check(alarm_two_o, exp_a2);
    end
    own_current_i = 10'd300;
    share_current_i = 10'd199;
    exp_a2[A2_DELIVERY] = 1'b1;
    cyc(6);
    share_current_i = 10'd300;
    check(alarm_two_o, exp_a2);
    await(4, 10);
    ack();
    check(smbalert_oe_o, 1'b0);
    alarm_one_src_i = 8'h10;
    cyc(6);
    alarm_one_src_i = 8'h00;
    await(4, 10);
    cyc(6);
    check(alarm_one_o, 8'h10);
    ack();
    // Identification blink
    send(CMD_IDENTIFY_START);
    check(lamp_o, 4'hf);
    cyc(IDENT_ON_MS * TK - 60);
    check(lamp_o, 4'hf);
    cyc(80);
    check(lamp_o, 4'h0);
    cyc(IDENT_OFF_MS * TK);
    check(lamp_o, 4'hf);
    send(CMD_IDENTIFY_STOP);
    // Back to normal lamps: alarm two, no remove, output on, input ok
    check(lamp_o, 4'hb);
    // Remove indicator flash
    send(CMD_REMOVE_FLASH);
    check({remove_lamp_o, lamp_o[2]}, 2'b11);
    cyc(REMOVE_HALF_MS * TK - 40);
    check(remove_lamp_o, 1'b1);
    cyc(80);
    check(remove_lamp_o, 1'b0);
    send(CMD_REMOVE_OFF);
    cyc(REMOVE_HALF_MS * TK);
    check(remove_lamp_o, 1'b0);
    // Write protect window
    send(CMD_WP_LIFT);
    check(eeprom_wp_o, 1'b1);
    cyc(WP_DELAY_MS * TK + 20);
    check(eeprom_wp_o, 1'b0);
    send(CMD_WP_SET);
    check(eeprom_wp_o, 1'b1);
    host_cmd_model_i.send(CMD_ISO_TEST);
    await(3, 40);
    await(0, 100);
    // Low output is over-current, 39.0 V itself is not
    vout_i = 10'd390;
    cyc(10);
    check(output_on_o, 1'b1);
    vout_i = 10'd389;
    await(2, 20);
    vout_i = 10'd540;
    // Lamp register trails the state by one cycle
    cyc(1);
    check({alarm_one_o[A1_OVER_CURRENT], lamp_o[1]}, 2'b10);
    cyc(RETRY_DELAY_MS * TK - 40);
    check(output_on_o, 1'b0);
    await(1, 80);
    cyc(4);
    check({alarm_two_o, alarm_one_o, status_two_o}, 24'h000004);
    send(CMD_CLEAR_FLAGS);
    check(status_two_o, 8'h00);
    // Inhibit latches an over-temperature trip
    send(CMD_INHIBIT);
    check(inhibit_o, 1'b1);
    alarm_one_src_i = 8'h20;
    await(2, 20);
    alarm_one_src_i = 8'h00;
    cyc(RETRY_DELAY_MS * TK + 400);
    check({output_on_o, lamp_o[1]}, 2'b00);
    enable_off_i = 1'b1;
    cyc(OFF_HOLD_MS * TK / 2);
    enable_off_i = 1'b0;
    cyc(200 * TK);
    check(output_on_o, 1'b0);
    // Host holds the unit off before bringing it back
    host_off_i = 1'b1;
    cyc(OFF_HOLD_MS * TK + 100);
    host_off_i = 1'b0;
    await(1, 100);
    check(inhibit_o, 1'b1);
    send(CMD_AUTO_RESTART);
    check(inhibit_o, 1'b0);
    // Over-voltage: three retries, the fourth trip latches
    for (int i = 0; i < 4; i++)
    begin
      alarm_one_src_i = 8'h04;
      await(2, 20);
      alarm_one_src_i = 8'h00;
      cyc(RETRY_DELAY_MS * TK - 40);
      check(output_on_o, 1'b0);
      if (i < 3)
        await(1, 80);
    end
    cyc(RETRY_DELAY_MS * TK);
    check(output_on_o, 1'b0);
    send(CMD_AUTO_RESTART);
    await(1, 20);
    test_done();
  end
endmodule
